// ### core/sgr_regs.sv
// module: error event mask and general-purpose pin dword of configuration space
`timescale 1ns/1ps
`default_nettype none
// How it works
// - error output asserts for an event only when unmasked and reporting enabled
// - mask bits 1 and 6 both gate the no-read-data event
// - mask bits 2 and 5 both gate the delayed-write non-delivery event
// - mask bit 3 gates target abort during posted write delivery
// - mask bit 4 gates master abort during posted write delivery
// - mask bits 0 and 7 read zero and reset to zero
// - writing one to a data-clear bit drives that pin low if enabled
// - writing one to a data-set bit, with that pin's data-clear bit zero, drives that pin high if enabled
// - input-only pins stay undriven whatever data is written
// - writing zero changes nothing; fields read last written value; reset zero
// - writing one to an enable-clear bit makes that pin input only
// - writing one to an enable-set bit, with that pin's enable-clear bit zero, turns on that pin's driver
// - lowest field bit acts on pin 0, highest on pin 3
module sgr_regs
  import sgr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rack_o,
  input  wire logic        error_report_enable_i,
  input  wire logic [6:1]  evt_i,
  output logic             primary_system_error_out_n_o,
  input  wire logic [3:0]  gpio_i,
  output logic      [3:0]  gpio_o,
  output logic      [3:0]  gpio_oe_n_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]  mask;
  logic [3:0]  data_clr_f;
  logic [3:0]  data_set_f;
  logic [3:0]  oe_clr_f;
  logic [3:0]  oe_set_f;
  logic        hit;
  logic        wr_b0;
  logic        wr_b1;
  logic        wr_b2;
  logic [7:0]  evt_vec;
  logic        next_serr;
  logic [31:0] next_rdata;

  sgr_pin_if pin_bus ();

  assign hit   = (cfg_addr_i[7:2] == SGR_CFG_OFFSET[7:2]);
  assign wr_b0 = cfg_wr_i && hit && cfg_be_i[0];
  assign wr_b1 = cfg_wr_i && hit && cfg_be_i[1];
  assign wr_b2 = cfg_wr_i && hit && cfg_be_i[2];

  // ---------------------------------------------------------------
  // event mask byte
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= SGR_MASK_RST;
    end else if (wr_b0) begin
      // reserved positions never store, so they always read zero
      mask <= cfg_wdata_i[SGR_MASK_LSB +: 8] & SGR_MASK_WRITABLE;
    end
  end

  // ---------------------------------------------------------------
  // set and clear fields, kept as last written for readback
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_clr_f <= SGR_FIELD_RST;
      data_set_f <= SGR_FIELD_RST;
      oe_clr_f   <= SGR_FIELD_RST;
      oe_set_f   <= SGR_FIELD_RST;
    end else begin
      if (wr_b1) begin
        data_clr_f <= cfg_wdata_i[SGR_DATA_CLR_LSB +: 4];
        data_set_f <= cfg_wdata_i[SGR_DATA_SET_LSB +: 4];
      end
      if (wr_b2) begin
        oe_clr_f <= cfg_wdata_i[SGR_OE_CLR_LSB +: 4];
        oe_set_f <= cfg_wdata_i[SGR_OE_SET_LSB +: 4];
      end
    end
  end

  // strobes last one cycle; a zero bit leaves the pin state alone
  assign pin_bus.data_clr = wr_b1 ? cfg_wdata_i[SGR_DATA_CLR_LSB +: 4] : 4'h0;
  assign pin_bus.data_set = wr_b1 ? cfg_wdata_i[SGR_DATA_SET_LSB +: 4] : 4'h0;
  assign pin_bus.oe_clr   = wr_b2 ? cfg_wdata_i[SGR_OE_CLR_LSB +: 4] : 4'h0;
  assign pin_bus.oe_set   = wr_b2 ? cfg_wdata_i[SGR_OE_SET_LSB +: 4] : 4'h0;

  sgr_pin_unit u_pins (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .ctl         (pin_bus.pin_side),
    .gpio_i      (gpio_i),
    .gpio_o      (gpio_o),
    .gpio_oe_n_o (gpio_oe_n_o)
  );

  // ---------------------------------------------------------------
  // system error output
  // ---------------------------------------------------------------
  // two mask positions name the same event twice; either one suppresses it
  always_comb begin
    evt_vec    = 8'h00;
    evt_vec[SGR_MB_RD_NODATA_A] = evt_i[SGR_MB_RD_NODATA_A] & ~mask[SGR_MB_RD_NODATA_B];
    evt_vec[SGR_MB_RD_NODATA_B] = evt_i[SGR_MB_RD_NODATA_B] & ~mask[SGR_MB_RD_NODATA_A];
    evt_vec[SGR_MB_WR_NODLV_A]  = evt_i[SGR_MB_WR_NODLV_A] & ~mask[SGR_MB_WR_NODLV_B];
    evt_vec[SGR_MB_WR_NODLV_B]  = evt_i[SGR_MB_WR_NODLV_B] & ~mask[SGR_MB_WR_NODLV_A];
    evt_vec[SGR_MB_TGT_ABORT]   = evt_i[SGR_MB_TGT_ABORT];
    evt_vec[SGR_MB_MST_ABORT]   = evt_i[SGR_MB_MST_ABORT];
    next_serr  = error_report_enable_i && (|(evt_vec & ~mask));
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      primary_system_error_out_n_o <= 1'b1;
    end else begin
      primary_system_error_out_n_o <= ~next_serr;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit) begin
      next_rdata[SGR_MASK_LSB +: 8]     = mask;
      next_rdata[SGR_DATA_CLR_LSB +: 4] = data_clr_f;
      next_rdata[SGR_DATA_SET_LSB +: 4] = data_set_f;
      next_rdata[SGR_OE_CLR_LSB +: 4]   = oe_clr_f;
      next_rdata[SGR_OE_SET_LSB +: 4]   = oe_set_f;
      next_rdata[SGR_PIN_LVL_LSB +: 4]  = pin_bus.pin_lvl;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_rack_o  <= 1'b0;
    end else begin
      cfg_rack_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_SERR_GATE: assert property (
    next_serr |=> !primary_system_error_out_n_o ##1
      (primary_system_error_out_n_o == !$past(next_serr)))
    else $error("error output does not follow gated events");
  AST_RD_NODATA: assert property (
    (evt_i[1] && (mask[1] || mask[6])) && !(|evt_i[5:2]) && !evt_i[6]
      |=> primary_system_error_out_n_o)
    else $error("masked no-read-data event raised error output");
  AST_WR_NODLV: assert property (
    (error_report_enable_i && evt_i[5] && !mask[5] && !mask[2])
      |=> !primary_system_error_out_n_o)
    else $error("unmasked delayed-write event did not raise error output");
  AST_TGT_ABORT: assert property (
    (evt_i == 6'h04 && mask[3]) |=> primary_system_error_out_n_o)
    else $error("masked target abort raised error output");
  AST_MST_ABORT: assert property (
    (error_report_enable_i && evt_i[4] && !mask[4])
      |=> !primary_system_error_out_n_o)
    else $error("unmasked master abort did not raise error output");
  AST_RSVD_ZERO: assert property (
    cfg_rack_o |-> (cfg_rdata_o[0] == 1'b0 && cfg_rdata_o[7] == 1'b0))
    else $error("reserved mask bits read nonzero");
  AST_DATA_CLR: assert property (
    (wr_b1 && cfg_wdata_i[8]) |=> (gpio_o[0] == 1'b0))
    else $error("data clear did not drive pin 0 low");
  AST_DATA_SET: assert property (
    (wr_b1 && cfg_wdata_i[15] && !cfg_wdata_i[11]) |=> gpio_o[3])
    else $error("data set did not drive pin 3 high");
  AST_NO_WRITE: assert property (
    !cfg_wr_i |=> ($stable(gpio_o) && $stable(gpio_oe_n_o)))
    else $error("pin state changed without a write");
  AST_OE_CLR: assert property (
    (wr_b2 && cfg_wdata_i[16]) |=> gpio_oe_n_o[0] ##1
      (gpio_oe_n_o[0] || $past(wr_b2)))
    else $error("enable clear did not release pin 0");
  AST_OE_SET: assert property (
    (wr_b2 && cfg_wdata_i[22] && !cfg_wdata_i[18]) |=> !gpio_oe_n_o[2])
    else $error("enable set did not drive pin 2");
  AST_MISS_ZERO: assert property (
    (cfg_rd_i && !hit) |=> (cfg_rack_o && cfg_rdata_o == 32'h0000_0000))
    else $error("read of another offset returned data");
  AST_RACK_NEXT: assert property (
    cfg_rd_i |=> cfg_rack_o)
    else $error("read strobe not answered in the next cycle");
  AST_RDATA_HOLD: assert property (
    !cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data changed without a read");

  COV_SERR:    cover property (next_serr ##1 !primary_system_error_out_n_o);
  COV_MASKED:  cover property (error_report_enable_i && |evt_i && !next_serr);
  COV_DRIVE:   cover property (wr_b2 && cfg_wdata_i[20] ##1 wr_b1 && cfg_wdata_i[12]);
  COV_CLR_WIN: cover property (wr_b1 && cfg_wdata_i[8] && cfg_wdata_i[12]);

endmodule
`default_nettype wire

// ### core/sgr_pkg.sv
// package: offsets, field positions and reset values of the error-mask and pin dword
package sgr_pkg;

  // ---------------------------------------------------------------
  // configuration space location
  // ---------------------------------------------------------------
  localparam logic [7:0] SGR_CFG_OFFSET     = 8'h64;
  localparam int         SGR_PIN_COUNT      = 4;

  // ---------------------------------------------------------------
  // field positions inside the dword
  // ---------------------------------------------------------------
  localparam int SGR_MASK_LSB       = 0;
  localparam int SGR_DATA_CLR_LSB   = 8;
  localparam int SGR_DATA_SET_LSB   = 12;
  localparam int SGR_OE_CLR_LSB     = 16;
  localparam int SGR_OE_SET_LSB     = 20;
  localparam int SGR_PIN_LVL_LSB    = 24;

  // mask bit positions; the no-read-data and delayed-write events take two each
  localparam int SGR_MB_RD_NODATA_A = 1;
  localparam int SGR_MB_WR_NODLV_A  = 2;
  localparam int SGR_MB_TGT_ABORT   = 3;
  localparam int SGR_MB_MST_ABORT   = 4;
  localparam int SGR_MB_WR_NODLV_B  = 5;
  localparam int SGR_MB_RD_NODATA_B = 6;

  // ---------------------------------------------------------------
  // reset values and reserved bits
  // ---------------------------------------------------------------
  localparam logic [7:0] SGR_MASK_RST       = 8'h00;
  localparam logic [7:0] SGR_MASK_WRITABLE  = 8'h7e;
  localparam logic [3:0] SGR_FIELD_RST      = 4'h0;
  localparam logic [3:0] SGR_PIN_DATA_RST   = 4'h0;
  localparam logic [3:0] SGR_PIN_OE_RST     = 4'h0;
  localparam logic [2:0] SGR_SYNC_RST       = 3'h0;

endpackage

// ### core/sgr_pin_if.sv
// interface: set and clear strobes from the register bank to the pin unit
`timescale 1ns/1ps
`default_nettype none
interface sgr_pin_if;
  logic [3:0] data_set;
  logic [3:0] data_clr;
  logic [3:0] oe_set;
  logic [3:0] oe_clr;
  logic [3:0] pin_lvl;

  modport reg_side (output data_set, output data_clr, output oe_set, output oe_clr,
                    input pin_lvl);
  modport pin_side (input data_set, input data_clr, input oe_set, input oe_clr,
                    output pin_lvl);
endinterface
`default_nettype wire

// ### core/sgr_pin_unit.sv
// module: four general-purpose pins with data and enable state and input synchroniser
`timescale 1ns/1ps
`default_nettype none
module sgr_pin_unit
  import sgr_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  sgr_pin_if.pin_side     ctl,
  input  wire logic [3:0] gpio_i,
  output logic      [3:0] gpio_o,
  output logic      [3:0] gpio_oe_n_o
);

  logic [3:0] pin_data;
  logic [3:0] pin_oe_n;
  logic [2:0] sync [SGR_PIN_COUNT];
  logic [3:0] pin_lvl;

  // ---------------------------------------------------------------
  // per-pin state
  // ---------------------------------------------------------------
  // the clear is applied last so it wins over a set of the same bit
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_data <= SGR_PIN_DATA_RST;
      pin_oe_n <= ~SGR_PIN_OE_RST;
    end else begin
      pin_data <= (pin_data | ctl.data_set) & ~ctl.data_clr;
      // enable kept active low in the flop so the pin sees no gate after it
      pin_oe_n <= (pin_oe_n & ~ctl.oe_set) | ctl.oe_clr;
    end
  end

  assign gpio_o      = pin_data;
  // input-only pins keep their driver off whatever data is held
  assign gpio_oe_n_o = pin_oe_n;

  // ---------------------------------------------------------------
  // pin level synchroniser
  // ---------------------------------------------------------------
  genvar g;
  for (g = 0; g < SGR_PIN_COUNT; g++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sync[g]    <= SGR_SYNC_RST;
        pin_lvl[g] <= 1'b0;
      end else begin
        sync[g] <= {sync[g][1:0], gpio_i[g]};
        if (sync[g][1] == sync[g][2]) begin
          pin_lvl[g] <= sync[g][2];
        end
      end
    end
  end

  assign ctl.pin_lvl = pin_lvl;

endmodule
`default_nettype wire

// ### test/sgr_host_model.sv
// partner model: configuration host issuing single read and write cycles
`timescale 1ns/1ps
`default_nettype none
module sgr_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        cfg_rack_i,
  output logic             cfg_wr_o,
  output logic             cfg_rd_o,
  output logic      [7:0]  cfg_addr_o,
  output logic      [3:0]  cfg_be_o,
  output logic      [31:0] cfg_wdata_o
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial begin
    cfg_wr_o    = 1'b0;
    cfg_rd_o    = 1'b0;
    cfg_addr_o  = 8'h00;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h0;
  end

  // released address and data lines show the inverse so stale values never look valid
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys_i);
    #1;
    cfg_addr_o  = a;
    cfg_be_o    = be;
    cfg_wdata_o = d;
    cfg_wr_o    = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cfg_wr_o    = 1'b0;
    cfg_addr_o  = ~a;
    cfg_wdata_o = ~d;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    d = 32'hx;
    @(posedge clk_sys_i);
    #1;
    cfg_addr_o = a;
    cfg_rd_o   = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cfg_rd_o   = 1'b0;
    cfg_addr_o = ~a;
    // the answer must stand one cycle after the strobe; a late one leaves d unknown
    @(posedge clk_sys_i);
    if (cfg_rack_i === 1'b1) begin
      d = cfg_rdata_i;
    end
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// testbench: error event mask and general-purpose pin dword
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sgr_pkg::*;
  logic        clk_sys_i, rst_n_i, cfg_wr, cfg_rd, cfg_rack, en, serr_n;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be, gpio_o, gpio_oe_n, ext, pin_lvl;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic [6:1]  evt;
  int          mismatches, n_tests;

  // pins not driven by the block follow the outside level
  assign pin_lvl = (gpio_oe_n & ext) | (~gpio_oe_n & gpio_o);

  sgr_regs dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr),
    .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(cfg_rdata), .cfg_rack_o(cfg_rack), .error_report_enable_i(en),
    .evt_i(evt), .primary_system_error_out_n_o(serr_n), .gpio_i(pin_lvl),
    .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n));
  sgr_host_model host (.clk_sys_i(clk_sys_i), .cfg_rdata_i(cfg_rdata),
    .cfg_rack_i(cfg_rack), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_addr_o(cfg_addr),
    .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd64(input logic [31:0] exp);
    host.cfg_read(SGR_CFG_OFFSET, d);
    chk(d & 32'h00ffffff, exp);
  endtask

  task automatic pulse(input int i, input logic e, input logic exp);
    @(posedge clk_sys_i);
    #1;
    en     = e;
    evt[i] = 1'b1;
    @(posedge clk_sys_i);
    #1;
    evt = 6'h00;
    chk(32'(serr_n), 32'(exp));
    @(posedge clk_sys_i);
    #1;
    chk(32'(serr_n), 32'h1);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd64(32'h0);
    chk(32'({gpio_oe_n, gpio_o, 3'h0, serr_n}), 32'hf01);
  endtask

  task automatic t_mask();
    host.cfg_write(SGR_CFG_OFFSET, 4'h1, 32'hff);
    rd64(32'h7e);
  endtask

  // partner bit 7-i shares the event for pairs (1,6) and (2,5) only
  task automatic t_events();
    for (int i = 1; i <= 6; i++) begin
      host.cfg_write(SGR_CFG_OFFSET, 4'h1, 32'h0);
      pulse(i, 1'b1, 1'b0);
      pulse(i, 1'b0, 1'b1);
      host.cfg_write(SGR_CFG_OFFSET, 4'h1, 32'(1 << i));
      pulse(i, 1'b1, 1'b1);
      host.cfg_write(SGR_CFG_OFFSET, 4'h1, 32'(1 << (7 - i)));
      pulse(i, 1'b1, (i == 3 || i == 4) ? 1'b0 : 1'b1);
    end
    host.cfg_write(SGR_CFG_OFFSET, 4'h1, 32'h0);
  endtask

  task automatic t_pins();
    host.cfg_write(SGR_CFG_OFFSET, 4'h4, 32'h0050_0000);
    chk(32'(gpio_oe_n), 32'ha);
    host.cfg_write(SGR_CFG_OFFSET, 4'h2, 32'h0000_f000);
    chk(32'({gpio_o, pin_lvl}), 32'hf5);
    host.cfg_write(SGR_CFG_OFFSET, 4'h2, 32'h0000_0300);
    chk(32'({gpio_o, pin_lvl}), 32'hc4);
    rd64(32'h0050_0300);
    host.cfg_write(SGR_CFG_OFFSET, 4'h2, 32'h0000_4400);
    chk(32'(gpio_o), 32'h8);
    host.cfg_write(SGR_CFG_OFFSET, 4'h2, 32'h0);
    chk(32'(gpio_o), 32'h8);
    host.cfg_write(SGR_CFG_OFFSET, 4'h4, 32'h0001_0000);
    chk(32'(gpio_oe_n), 32'hb);
  endtask

  task automatic t_offset();
    host.cfg_write(8'h68, 4'hf, 32'hffff_ffff);
    chk(32'({gpio_oe_n, gpio_o}), 32'hb8);
    host.cfg_read(8'h60, d);
    chk(d, 32'h0);
    rd64(32'h0001_0000);
  endtask

  // pins 0,1 input only follow the outside level; pin 2 drives its held zero
  task automatic t_levels();
    @(posedge clk_sys_i);
    #1;
    ext = 4'h3;
    repeat (6) @(posedge clk_sys_i);
    host.cfg_read(SGR_CFG_OFFSET, d);
    chk(32'(d[31:24]), 32'h03);
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // whole run needs well under 2000 cycles
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst_n_i    = 1'b0;
    en         = 1'b0;
    evt        = 6'h00;
    ext        = 4'h0;
    mismatches = 0;
    n_tests    = 0;
    repeat (16) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_mask();
    t_events();
    t_pins();
    t_offset();
    t_levels();
    report_and_stop();
  end
endmodule
`default_nettype wire
